// file: logic/cascaded_channel_divider_ctl.sv
// Operation
// (RULE_01) Stage two output stays low for low count plus one input cycles.
// (RULE_02) Stage two output stays high for high count plus one input cycles.
// (RULE_03) Stage one uses its own low and high nibble pair, same plus-one rule.
// (RULE_04) Four-bit phase offset per stage, stage two upper nibble, both reset zero.
// (RULE_05) Stage two bypass powers its divider down and passes its input clock.
// (RULE_06) Stage one bypass powers its divider down and passes its input clock.
// (RULE_07) Sync-ignore zero obeys the chip sync signal; one disregards it.
// (RULE_08) Static-level bit sets forced output level; needs sync-ignore set too.
// (RULE_09) Stage two start-level bit picks the first level of its waveform.
// (RULE_10) Stage one start-level bit picks the first level of its waveform.
// (RULE_11) Duty correction on while its disable bit is zero, off when one.
// (RULE_12) Stage one output clocks stage two; a bypassed stage divides by one.
//
// Chosen here: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "chan_div_defines.svh"

module cascaded_channel_divider_ctl (
  input  wire logic                 CLK,
  input  wire logic                 RESET_N,
  input  wire chan_div_pkg::addr_t  ADDR,
  input  wire chan_div_pkg::data_t  WDATA,
  input  wire logic                 WR,
  input  wire logic                 RD,
  output var  chan_div_pkg::data_t  RDATA,
  input  wire logic                 SYNC_N,
  output var  logic                 CH_OUT,
  output var  logic                 DUTY_FIX_ON
);
  import chan_div_pkg::*;

  // Register bank state
  data_t                  counts1;
  data_t                  next_counts1;
  data_t                  phase;
  data_t                  next_phase;
  data_t                  counts2;
  data_t                  next_counts2;
  logic [`CDC_CTRL_W-1:0] ctrl;
  logic [`CDC_CTRL_W-1:0] next_ctrl;
  logic                   duty_fix_disable;
  logic                   next_duty_fix_disable;
  data_t                  next_rdata;

  // Sync pin synchroniser
  logic                   sync_meta_n;
  logic                   sync_pin_n;

  // Distribution clock model and output stage
  logic                   ref_level;
  logic                   next_ref_level;
  logic                   ref_tick;
  logic                   next_ref_tick;
  logic                   next_ch_out;
  logic                   next_duty_fix_on;
  logic                   sync_hold;
  logic                   static_active;
  logic                   s1_tick;
  logic                   s1_level;
  logic                   s2_tick;
  logic                   s2_level;

  stage_cfg_if cfg1 ();
  stage_cfg_if cfg2 ();

  // Register writes; bits above the documented fields are not stored
  always_comb begin
    next_counts1          = counts1;
    next_phase            = phase;
    next_counts2          = counts2;
    next_ctrl             = ctrl;
    next_duty_fix_disable = duty_fix_disable;
    if (WR) begin
      if (ADDR == `CDC_OFS_COUNTS1) begin
        next_counts1 = WDATA;
      end else if (ADDR == `CDC_OFS_PHASE) begin
        next_phase = WDATA;
      end else if (ADDR == `CDC_OFS_COUNTS2) begin
        next_counts2 = WDATA;
      end else if (ADDR == `CDC_OFS_CTRL) begin
        next_ctrl = WDATA[`CDC_CTRL_W-1:0];
      end else if (ADDR == `CDC_OFS_DUTY) begin
        next_duty_fix_disable = WDATA[`CDC_BIT_DUTY_OFF];
      end
    end
  end

  // Read data stand for exactly one cycle after the strobe, zero otherwise
  always_comb begin
    next_rdata = 8'h00;
    if (RD) begin
      if (ADDR == `CDC_OFS_COUNTS1) begin
        next_rdata = counts1;
      end else if (ADDR == `CDC_OFS_PHASE) begin
        next_rdata = phase;
      end else if (ADDR == `CDC_OFS_COUNTS2) begin
        next_rdata = counts2;
      end else if (ADDR == `CDC_OFS_CTRL) begin
        next_rdata = {2'b00, ctrl};
      end else if (ADDR == `CDC_OFS_DUTY) begin
        next_rdata = {7'h00, duty_fix_disable};
      end else if (ADDR == `CDC_OFS_STATUS) begin
        next_rdata[`CDC_BIT_ST_OUT]  = CH_OUT;
        next_rdata[`CDC_BIT_ST_HELD] = sync_hold;
        next_rdata[`CDC_BIT_ST_S1]   = s1_level;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      counts1          <= `CDC_RST_COUNTS;
      phase            <= `CDC_RST_PHASE; // [RULE_04]
      counts2          <= `CDC_RST_COUNTS; // [RULE_01]
      ctrl             <= `CDC_RST_CTRL;
      duty_fix_disable <= `CDC_RST_DUTY;
      RDATA            <= 8'h00;
    end else begin
      counts1          <= next_counts1;
      phase            <= next_phase;
      counts2          <= next_counts2;
      ctrl             <= next_ctrl;
      duty_fix_disable <= next_duty_fix_disable;
      RDATA            <= next_rdata;
    end
  end

  // Sync pin is asynchronous to CLK, so two flops before any use
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      sync_meta_n <= 1'b1;
      sync_pin_n  <= 1'b1;
    end else begin
      sync_meta_n <= SYNC_N;
      sync_pin_n  <= sync_meta_n;
    end
  end

  // Sync-ignore cuts the pin off from both stages
  assign sync_hold     = !sync_pin_n && !ctrl[`CDC_BIT_NOSYNC]; // [RULE_07]
  // Static level shows only while a sync is held off by sync-ignore
  assign static_active = !sync_pin_n && ctrl[`CDC_BIT_NOSYNC]; // [RULE_08]

  // Stage settings: stage one from its own nibble pair, stage two from the other
  assign cfg1.low        = counts1[`CDC_HI_NIB_MSB:`CDC_HI_NIB_LSB]; // [RULE_03]
  assign cfg1.high       = counts1[`CDC_LO_NIB_MSB:`CDC_LO_NIB_LSB]; // [RULE_03]
  assign cfg1.phase      = phase[`CDC_LO_NIB_MSB:`CDC_LO_NIB_LSB]; // [RULE_04]
  assign cfg1.start_high = ctrl[`CDC_BIT_START1]; // [RULE_10]
  assign cfg1.bypass     = ctrl[`CDC_BIT_BYPASS1]; // [RULE_06]
  assign cfg2.low        = counts2[`CDC_HI_NIB_MSB:`CDC_HI_NIB_LSB]; // [RULE_01]
  assign cfg2.high       = counts2[`CDC_LO_NIB_MSB:`CDC_LO_NIB_LSB]; // [RULE_02]
  assign cfg2.phase      = phase[`CDC_HI_NIB_MSB:`CDC_HI_NIB_LSB]; // [RULE_04]
  assign cfg2.start_high = ctrl[`CDC_BIT_START2]; // [RULE_09]
  assign cfg2.bypass     = ctrl[`CDC_BIT_BYPASS2]; // [RULE_05]

  // Input clock model: one input clock cycle is two CLK cycles, so a
  // bypassed stage can still show a real high and low half
  always_comb begin
    next_ref_level = !ref_level;
    next_ref_tick  = !ref_level;
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      ref_level <= 1'b0;
      ref_tick  <= 1'b0;
    end else begin
      ref_level <= next_ref_level;
      ref_tick  <= next_ref_tick;
    end
  end

  div_stage u_stage1 (
    .clk       (CLK),
    .reset_n   (RESET_N),
    .cfg       (cfg1.dst),
    .hold      (sync_hold),
    .in_tick   (ref_tick),
    .in_level  (ref_level),
    .out_tick  (s1_tick),
    .out_level (s1_level)
  );

  // Stage two steps only on stage one rising edges [RULE_12]
  div_stage u_stage2 (
    .clk       (CLK),
    .reset_n   (RESET_N),
    .cfg       (cfg2.dst),
    .hold      (sync_hold),
    .in_tick   (s1_tick),
    .in_level  (s1_level),
    .out_tick  (s2_tick),
    .out_level (s2_level)
  );

  // Group output and correction flag, both straight from flops
  always_comb begin
    next_ch_out      = static_active ? ctrl[`CDC_BIT_STATIC] : s2_level; // [RULE_08]
    next_duty_fix_on = !duty_fix_disable; // [RULE_11]
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      CH_OUT      <= 1'b0;
      DUTY_FIX_ON <= 1'b1;
    end else begin
      CH_OUT      <= next_ch_out;
      DUTY_FIX_ON <= next_duty_fix_on;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  // A bypassed stage passes its input on even while held, so only chains with neither stage bypassed must stop
  a_sync_obeyed: assert property (sync_hold && !cfg1.bypass && !cfg2.bypass |=> !s1_tick && !s2_tick ##1 !s2_tick) // [RULE_07]
    else $error("stages kept running during an obeyed sync");
  a_static_needs_nosync: assert property (!static_active |=> CH_OUT == $past(s2_level)) // [RULE_08]
    else $error("forced level shown without sync-ignore and a held sync");
  a_static_level: assert property (static_active |=> CH_OUT == $past(ctrl[`CDC_BIT_STATIC])) // [RULE_08]
    else $error("forced level not shown on the output");
  a_duty_flag: assert property ($changed(duty_fix_disable) |=> DUTY_FIX_ON == !$past(duty_fix_disable)) // [RULE_11]
    else $error("duty correction flag does not track its disable bit");

  c_sync_release: cover property (sync_hold ##1 !sync_hold ##[1:40] s2_tick);
  c_forced_high: cover property (static_active && ctrl[`CDC_BIT_STATIC] ##1 CH_OUT);
  c_full_bypass: cover property (cfg1.bypass && cfg2.bypass ##2 CH_OUT ##1 !CH_OUT);
endmodule : cascaded_channel_divider_ctl

`default_nettype wire

// file: logic/chan_div_defines.svh
`ifndef CHAN_DIV_DEFINES_SVH
`define CHAN_DIV_DEFINES_SVH

// Register bus geometry
`define CDC_ADDR_W        10
`define CDC_DATA_W        8

// Register offsets
`define CDC_OFS_COUNTS1   10'h19e
`define CDC_OFS_PHASE     10'h19f
`define CDC_OFS_COUNTS2   10'h1a0
`define CDC_OFS_CTRL      10'h1a1
`define CDC_OFS_DUTY      10'h1a2
`define CDC_OFS_STATUS    10'h1a3

// Nibble fields of the count and phase registers
`define CDC_HI_NIB_MSB    7
`define CDC_HI_NIB_LSB    4
`define CDC_LO_NIB_MSB    3
`define CDC_LO_NIB_LSB    0

// Control register bits
`define CDC_BIT_BYPASS2   5
`define CDC_BIT_BYPASS1   4
`define CDC_BIT_NOSYNC    3
`define CDC_BIT_STATIC    2
`define CDC_BIT_START2    1
`define CDC_BIT_START1    0
`define CDC_CTRL_W        6

// Duty correction register bit
`define CDC_BIT_DUTY_OFF  0

// Status register bits
`define CDC_BIT_ST_OUT    0
`define CDC_BIT_ST_HELD   1
`define CDC_BIT_ST_S1     2

// Reset values
`define CDC_RST_COUNTS    8'h00
`define CDC_RST_PHASE     8'h00
`define CDC_RST_CTRL      6'h00
`define CDC_RST_DUTY      1'b0

`endif

// file: logic/chan_div_pkg.sv
`default_nettype none
`include "chan_div_defines.svh"

package chan_div_pkg;
  typedef logic [`CDC_ADDR_W-1:0] addr_t;
  typedef logic [`CDC_DATA_W-1:0] data_t;
  typedef logic [3:0]             count_t;
  typedef enum logic [1:0] {
    ST_HOLD,
    ST_LOW,
    ST_HIGH
  } stage_state_e;
endpackage : chan_div_pkg

`default_nettype wire

// file: logic/stage_cfg_if.sv
`timescale 1ns/100ps
`default_nettype none

// Settings of one divider stage, from the register bank to the stage
interface stage_cfg_if;
  import chan_div_pkg::*;
  count_t low;
  count_t high;
  count_t phase;
  logic   start_high;
  logic   bypass;
  modport src (output low, output high, output phase, output start_high, output bypass);
  modport dst (input low, input high, input phase, input start_high, input bypass);
endinterface : stage_cfg_if

`default_nettype wire

// file: logic/div_stage.sv
`timescale 1ns/100ps
`default_nettype none

module div_stage (
  input  wire logic clk,
  input  wire logic reset_n,
  stage_cfg_if.dst  cfg,
  input  wire logic hold,
  input  wire logic in_tick,
  input  wire logic in_level,
  output var  logic out_tick,
  output var  logic out_level
);
  import chan_div_pkg::*;

  stage_state_e state;
  stage_state_e next_state;
  logic [4:0]   cnt;
  logic [4:0]   next_cnt;
  logic         next_tick;

  // Counter walks one step per input clock rising edge
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_tick  = 1'b0;
    if (cfg.bypass) begin
      // Counter parked at zero, input waveform passed through [RULE_05] [RULE_06]
      next_state = in_level ? ST_HIGH : ST_LOW;
      next_cnt   = 5'h00;
      next_tick  = in_tick;
    end else if (hold) begin
      next_state = ST_HOLD;
      next_cnt   = 5'h00;
    end else begin
      case (state)
        ST_HOLD: begin
          if (in_tick) begin
            // Start level and phase offset set the first half [RULE_09] [RULE_10] [RULE_04]
            next_state = cfg.start_high ? ST_HIGH : ST_LOW;
            next_cnt   = {1'b0, (cfg.start_high ? cfg.high : cfg.low)} + {1'b0, cfg.phase};
            next_tick  = cfg.start_high;
          end
        end
        ST_LOW: begin
          if (in_tick) begin
            if (cnt == 5'h00) begin
              next_state = ST_HIGH; // Low lasted low count + 1 cycles [RULE_01] [RULE_03]
              next_cnt   = {1'b0, cfg.high};
              next_tick  = 1'b1;
            end else begin
              next_cnt = cnt - 5'h01;
            end
          end
        end
        ST_HIGH: begin
          if (in_tick) begin
            if (cnt == 5'h00) begin
              next_state = ST_LOW; // High lasted high count + 1 cycles [RULE_02] [RULE_03]
              next_cnt   = {1'b0, cfg.low};
            end else begin
              next_cnt = cnt - 5'h01;
            end
          end
        end
        default: begin
          next_state = ST_HOLD;
          next_cnt   = 5'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state    <= ST_HOLD;
      cnt      <= 5'h00;
      out_tick <= 1'b0;
    end else begin
      state    <= next_state;
      cnt      <= next_cnt;
      out_tick <= next_tick;
    end
  end

  // A held stage already shows the level it will start with
  assign out_level = (state == ST_HIGH) || ((state == ST_HOLD) && cfg.start_high);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_bypass_follow: assert property (cfg.bypass && $past(cfg.bypass) |-> out_level == $past(in_level)) // [RULE_05] [RULE_06]
    else $error("bypassed stage does not follow its input");
  a_low_length: assert property (state == ST_LOW && cnt == 5'h00 && in_tick && !hold && !cfg.bypass
    |=> state == ST_HIGH && cnt == {1'b0, $past(cfg.high)}) // [RULE_01] [RULE_03]
    else $error("low phase did not end into high count");
  a_high_length: assert property (state == ST_HIGH && cnt == 5'h00 && in_tick && !hold && !cfg.bypass
    |=> state == ST_LOW && cnt == {1'b0, $past(cfg.low)}) // [RULE_02] [RULE_03]
    else $error("high phase did not end into low count");
  a_start_level: assert property (state == ST_HOLD && in_tick && !hold && !cfg.bypass
    |=> out_level == $past(cfg.start_high)) // [RULE_09] [RULE_10]
    else $error("stage began at the wrong level");
  a_phase_load: assert property (state == ST_HOLD && in_tick && !hold && !cfg.bypass && !cfg.start_high
    |=> cnt == {1'b0, $past(cfg.low)} + {1'b0, $past(cfg.phase)}) // [RULE_04]
    else $error("phase offset not added to first half");
  a_chain_step: assert property (!in_tick && !hold && !cfg.bypass && state != ST_HOLD
    |=> $stable(state) && $stable(cnt)) // [RULE_12]
    else $error("stage moved without an input clock edge");
endmodule : div_stage

`default_nettype wire

// file: verification/tb_cascaded_channel_divider_ctl.sv
`timescale 1ns/100ps
`default_nettype none
`include "chan_div_defines.svh"

module tb_cascaded_channel_divider_ctl;
  import chan_div_pkg::*;
  logic  CLK;
  logic  RESET_N;
  logic  WR;
  logic  RD;
  logic  SYNC_N;
  logic  CH_OUT;
  logic  DUTY_FIX_ON;
  addr_t ADDR;
  data_t WDATA;
  data_t RDATA;
  data_t exp_q[$];
  logic  rd_seen = 1'b0;
  int    bad_count = 0;
  int    checked = 0;
  int    cyc = 0;
  int    t0;
  int    tp;
  int    p;
  data_t d;
  addr_t regs[5] = '{`CDC_OFS_COUNTS1, `CDC_OFS_PHASE, `CDC_OFS_COUNTS2, `CDC_OFS_CTRL, `CDC_OFS_DUTY};
  data_t msk[5]  = '{8'hff, 8'hff, 8'hff, 8'h3f, 8'h01};
  data_t hc[6]   = '{8'h02, 8'h01, 8'h21, 8'h04, 8'h0c, 8'h08};
  logic  hout[6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  data_t hst[4]  = '{8'h03, 8'h06, 8'h07, 8'h02};

  cascaded_channel_divider_ctl cascaded_channel_divider_ctl_inst (
    .CLK         (CLK),
    .RESET_N     (RESET_N),
    .ADDR        (ADDR),
    .WDATA       (WDATA),
    .WR          (WR),
    .RD          (RD),
    .RDATA       (RDATA),
    .SYNC_N      (SYNC_N),
    .CH_OUT      (CH_OUT),
    .DUTY_FIX_ON (DUTY_FIX_ON)
  );

  // 100 ns clock
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end

  // Free cycle count, used to release sync on a fixed parity
  always @(posedge CLK) cyc <= cyc + 1;

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checked++;
    if (seen !== want) begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask : check

  // Read data stand only in the cycle after the strobe
  always @(posedge CLK) begin
    rd_seen <= RD;
    if (rd_seen === 1'b1) begin
      if (exp_q.size() == 0) check(16'h0, 16'hffff);
      else check({8'h00, RDATA}, {8'h00, exp_q.pop_front()});
    end
  end

  task automatic wr(input addr_t a, input data_t v);
    @(posedge CLK);
    ADDR  <= a;
    WDATA <= v;
    WR    <= 1'b1;
    @(posedge CLK);
    WR    <= 1'b0;
  endtask : wr

  task automatic rd(input addr_t a, input data_t e);
    @(posedge CLK);
    ADDR <= a;
    RD   <= 1'b1;
    exp_q.push_back(e);
    @(posedge CLK);
    RD   <= 1'b0;
  endtask : rd

  task automatic sync_hold();
    @(posedge CLK);
    SYNC_N <= 1'b0;
    repeat (8) @(posedge CLK);
  endtask : sync_hold

  // Release on an even cycle so the half-rate input clock lines up each time
  task automatic sync_release(output int t);
    int n;
    @(posedge CLK);
    while (cyc[0]) @(posedge CLK);
    SYNC_N <= 1'b1;
    n = 0;
    while (CH_OUT !== 1'b1 && n < 3000) begin
      @(posedge CLK);
      n++;
    end
    t = n;
  endtask : sync_release

  // One full high and low of the output, skipping any partial half
  task automatic meas(output int hi, output int lo);
    int n;
    n  = 0;
    hi = 0;
    lo = 0;
    while (CH_OUT !== 1'b0 && n < 3000) begin @(posedge CLK); n++; end
    while (CH_OUT !== 1'b1 && n < 3000) begin @(posedge CLK); n++; end
    while (CH_OUT === 1'b1 && hi < 3000) begin @(posedge CLK); hi++; end
    while (CH_OUT === 1'b0 && lo < 3000) begin @(posedge CLK); lo++; end
  endtask : meas

  task automatic div_case(input data_t c1, input data_t c2, input data_t ctl);
    int hi, lo, h1, l1, eh, el;
    wr(`CDC_OFS_COUNTS1, c1);
    wr(`CDC_OFS_COUNTS2, c2);
    wr(`CDC_OFS_CTRL, ctl);
    wr(`CDC_OFS_PHASE, 8'h00);
    sync_hold();
    SYNC_N <= 1'b1;
    meas(hi, lo);
    h1 = ctl[4] ? 1 : 2 * (c1[3:0] + 1);
    l1 = ctl[4] ? 1 : 2 * (c1[7:4] + 1);
    eh = ctl[5] ? h1 : (h1 + l1) * (c2[3:0] + 1);
    el = ctl[5] ? l1 : (h1 + l1) * (c2[7:4] + 1);
    check(16'(hi), 16'(eh));
    check(16'(lo), 16'(el));
  endtask : div_case

  task automatic stop_test();
    $display("counts: checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test

  // Watchdog well beyond the expected run length
  initial begin
    repeat (40000) @(posedge CLK);
    bad_count++;
    stop_test();
  end

  initial begin
    RESET_N = 1'b0;
    WR      = 1'b0;
    RD      = 1'b0;
    ADDR    = '0;
    WDATA   = '0;
    SYNC_N  = 1'b1;
    void'($urandom(33467));
    repeat (16) @(posedge CLK);
    check({15'h0, DUTY_FIX_ON}, 16'h1);
    RESET_N <= 1'b1;
    for (int i = 0; i < 5; i++) rd(regs[i], 8'h00);
    rd(10'h1a4, 8'h00);
    $display("test reset_values done");
    for (int i = 0; i < 5; i++) begin
      d = data_t'($urandom);
      wr(regs[i], d);
      rd(regs[i], d & msk[i]);
    end
    wr(10'h1a4, 8'h5a);
    rd(10'h1a4, 8'h00);
    $display("test register_access done");
    wr(`CDC_OFS_DUTY, 8'h01);
    repeat (2) @(posedge CLK);
    check({15'h0, DUTY_FIX_ON}, 16'h0);
    wr(`CDC_OFS_DUTY, 8'h00);
    repeat (2) @(posedge CLK);
    check({15'h0, DUTY_FIX_ON}, 16'h1);
    $display("test duty_fix done");
    div_case(8'h00, 8'h00, 8'h00);
    for (int i = 0; i < 4; i++) div_case(data_t'($urandom) & 8'h33, data_t'($urandom) & 8'h33, 8'h00);
    div_case(8'h00, 8'hf0, 8'h00);
    div_case(8'h21, 8'h13, 8'h10);
    div_case(8'h21, 8'h13, 8'h20);
    div_case(8'h21, 8'h13, 8'h30);
    $display("test divide_ratios done");
    // Held and forced levels, with status while held
    for (int i = 0; i < 6; i++) begin
      wr(`CDC_OFS_CTRL, hc[i]);
      sync_hold();
      check({15'h0, CH_OUT}, {15'h0, hout[i]});
      if (i < 4) rd(`CDC_OFS_STATUS, hst[i]);
      @(posedge CLK);
      SYNC_N <= 1'b1;
      repeat (4) @(posedge CLK);
    end
    $display("test sync_and_static done");
    // Phase adds input cycles before the first edge after release
    wr(`CDC_OFS_COUNTS1, 8'h00);
    wr(`CDC_OFS_COUNTS2, 8'h00);
    for (int s = 0; s < 2; s++) begin
      wr(`CDC_OFS_CTRL, s ? 8'h10 : 8'h20);
      wr(`CDC_OFS_PHASE, 8'h00);
      sync_hold();
      sync_release(t0);
      p = $urandom_range(15, 1);
      wr(`CDC_OFS_PHASE, 8'(p << (4 * s)));
      sync_hold();
      sync_release(tp);
      check(16'(tp - t0), 16'(2 * p));
    end
    $display("test phase_offset done");
    repeat (4) @(posedge CLK);
    stop_test();
  end
endmodule : tb_cascaded_channel_divider_ctl

`default_nettype wire
